// ### logic/emrt_pkg.sv
// shared constants, types and carriers for the extended mode register bank
// assumes commands are sampled on core_clk rising edges, one beat per cycle
package emrt_pkg;
   localparam int ADDR_W = 14;
   localparam int DQ_W = 16;
   localparam int STROBE_W = 2;
   localparam int STEP_W = 4;
   localparam logic [1:0] SEL_LOOP = 2'h1;
   localparam logic [1:0] SEL_REFRESH = 2'h2;
   localparam logic [1:0] SEL_THIRD = 2'h3;
   localparam logic [ADDR_W-1:0] EXT_RESET = 14'h0000;
   localparam int LOOP_OFF_BIT = 0;
   localparam int HALF_DRIVE_BIT = 1;
   localparam int TERM_LO_BIT = 2;
   localparam int DELAY_LSB = 3;
   localparam int TERM_HI_BIT = 6;
   localparam int TRIM_LSB = 7;
   localparam int STROBE_COMP_OFF_BIT = 10;
   localparam int OUTPUT_OFF_BIT = 12;
   localparam int PARTIAL_LSB = 0;
   localparam int DCC_BIT = 3;
   localparam int FAST_REFRESH_BIT = 7;
   localparam logic [2:0] TRIM_EXIT = 3'h0;
   localparam logic [2:0] TRIM_DRIVE_HIGH = 3'h1;
   localparam logic [2:0] TRIM_DRIVE_LOW = 3'h2;
   localparam logic [2:0] TRIM_ADJUST = 3'h4;
   localparam logic [2:0] TRIM_DEFAULT = 3'h7;
   localparam logic [1:0] LAST_BEAT = 2'h3;
   localparam logic [STEP_W-1:0] STEP_MAX = 4'hF;
   localparam logic [STEP_W-1:0] STEP_MIN = 4'h0;
   localparam logic [STEP_W-1:0] STEP_DEFAULT = 4'h8;
   // adjust codes are {bit time 0, 1, 2, 3}
   localparam logic [3:0] CODE_UP_INC = 4'h1;
   localparam logic [3:0] CODE_UP_DEC = 4'h2;
   localparam logic [3:0] CODE_DN_INC = 4'h4;
   localparam logic [3:0] CODE_DN_DEC = 4'h8;
   localparam logic [3:0] CODE_BOTH_INC = 4'h5;
   localparam logic [3:0] CODE_UPDEC_DNINC = 4'h6;
   localparam logic [3:0] CODE_UPINC_DNDEC = 4'h9;
   localparam logic [3:0] CODE_BOTH_DEC = 4'hA;

   typedef enum logic [1:0] {STEP_HOLD, STEP_INC, STEP_DEC} emrt_step_t;
   typedef enum logic [1:0] {TRIM_OFF, TRIM_HIGH, TRIM_LOW, TRIM_ADJ}
      emrt_trim_mode_t;
   typedef enum logic [1:0] {TERM_OFF, TERM_75, TERM_150, TERM_50}
      emrt_term_t;
   typedef enum logic {ADJ_IDLE, ADJ_COLLECT} emrt_adj_state_t;

   typedef struct packed {
      logic csN;
      logic rasN;
      logic casN;
      logic weN;
      logic [2:0] ba;
      logic [ADDR_W-1:0] addr;
   } emrt_cmd_t;

   typedef struct packed {
      logic [DQ_W-1:0] dq;
      logic dqOe;
      logic [STROBE_W-1:0] dqs;
      logic dqsOe;
      logic [STROBE_W-1:0] dqsComp;
      logic dqsCompOe;
   } emrt_pins_t;

   typedef struct packed {
      logic loopEnabled;
      logic halfDrive;
      logic [2:0] postedDelay;
      emrt_term_t term;
      logic strobeCompOff;
      logic outputOff;
      logic [2:0] partialArray;
      logic dccControl;
      logic fastRefresh;
   } emrt_config_t;
endpackage

// ### logic/emrt_trim_steps.sv
// saturating pull-up and pull-down driver trim step counters
// assumes apply is a one-cycle pulse carrying decoded step actions
`timescale 1ns/1ps
module emrt_trim_steps
   import emrt_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic loadDefault,
   input wire logic apply,
   input wire emrt_step_t upAct,
   input wire emrt_step_t downAct,
   output logic [STEP_W-1:0] pullUpStep,
   output logic [STEP_W-1:0] pullDownStep
);
   logic [STEP_W-1:0] step [2];
   emrt_step_t act [2];

   assign act[0] = upAct;
   assign act[1] = downAct;

   for (genvar i = 0; i < 2; i++) begin : g_step
      logic [STEP_W-1:0] next_step;
      always_comb begin
         next_step = step[i];
         if (loadDefault) begin
            next_step = STEP_DEFAULT;
         end else if (apply) begin
            // limits swallow further codes rather than wrapping
            if (act[i] == STEP_INC && step[i] != STEP_MAX) begin
               next_step = step[i] + 4'h1;
            end else if (act[i] == STEP_DEC && step[i] != STEP_MIN) begin
               next_step = step[i] - 4'h1;
            end
         end
      end
      always_ff @(posedge core_clk) begin
         if (!reset_n) begin
            step[i] <= STEP_DEFAULT;
         end else begin
            step[i] <= next_step;
         end
      end
   end

   // one shared pull-up and one shared pull-down setting drive every data driver
   assign pullUpStep = step[0];
   assign pullDownStep = step[1];

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   a_sat_top_hold: assert property (
      apply && !loadDefault && upAct == STEP_INC && pullUpStep == STEP_MAX
      |=> pullUpStep == STEP_MAX)
      else $error("pull-up step wrapped past top");
   a_sat_bottom_hold: assert property (
      apply && !loadDefault && downAct == STEP_DEC
      && pullDownStep == STEP_MIN |=> pullDownStep == STEP_MIN)
      else $error("pull-down step wrapped past bottom");
   a_step_inc_one: assert property (
      apply && !loadDefault && upAct == STEP_INC && pullUpStep != STEP_MAX
      |=> pullUpStep == $past(pullUpStep) + 4'h1)
      else $error("pull-up step did not rise by one");
endmodule

// ### logic/emrt_ext_regs.sv
// extended mode register bank with driver impedance trim flow
// assumes the controller keeps precharge, cycle time and exit-write order
`timescale 1ns/1ps
module emrt_ext_regs
   import emrt_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic cke,
   input wire emrt_cmd_t cmd,
   input wire logic allBanksIdle,
   input wire logic selfRefresh,
   input wire logic [DQ_W-1:0] dqIn,
   input wire logic dqBeat,
   output emrt_pins_t pins,
   output emrt_config_t fields,
   output logic loopRunning,
   output emrt_trim_mode_t trimMode,
   output logic [STEP_W-1:0] pullUpStep,
   output logic [STEP_W-1:0] pullDownStep,
   output logic [ADDR_W-1:0] extConfigLoopDriveLatency,
   output logic [ADDR_W-1:0] extConfigRefreshFeatures,
   output logic [ADDR_W-1:0] extConfigReservedThird
);
   logic extWrite;
   logic [1:0] regSel;
   logic [2:0] trimField;
   logic loopWrite;

   // command decode
   assign regSel = cmd.ba[1:0];
   assign extWrite = cke && !cmd.csN && !cmd.rasN && !cmd.casN
      && !cmd.weN && regSel != 2'h0 && allBanksIdle;
   assign loopWrite = extWrite && regSel == SEL_LOOP;
   assign trimField = cmd.addr[TRIM_LSB +: 3];

   // register storage
   logic [ADDR_W-1:0] next_loopReg;
   logic [ADDR_W-1:0] next_refreshReg;
   logic [ADDR_W-1:0] next_thirdReg;

   always_comb begin
      next_loopReg = extConfigLoopDriveLatency;
      next_refreshReg = extConfigRefreshFeatures;
      next_thirdReg = extConfigReservedThird;
      if (loopWrite) begin
         next_loopReg = cmd.addr;
      end
      if (extWrite && regSel == SEL_REFRESH) begin
         next_refreshReg = cmd.addr;
      end
      if (extWrite && regSel == SEL_THIRD) begin
         next_thirdReg = cmd.addr;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         extConfigLoopDriveLatency <= EXT_RESET;
         extConfigRefreshFeatures <= EXT_RESET;
         extConfigReservedThird <= EXT_RESET;
      end else begin
         extConfigLoopDriveLatency <= next_loopReg;
         extConfigRefreshFeatures <= next_refreshReg;
         extConfigReservedThird <= next_thirdReg;
      end
   end

   // field view; the third register has no function and only stores
   always_comb begin
      fields.loopEnabled = !extConfigLoopDriveLatency[LOOP_OFF_BIT];
      fields.halfDrive = extConfigLoopDriveLatency[HALF_DRIVE_BIT];
      fields.postedDelay = extConfigLoopDriveLatency[DELAY_LSB +: 3];
      unique case ({extConfigLoopDriveLatency[TERM_HI_BIT],
                    extConfigLoopDriveLatency[TERM_LO_BIT]})
         2'h1: fields.term = TERM_75;
         2'h2: fields.term = TERM_150;
         2'h3: fields.term = TERM_50;
         default: fields.term = TERM_OFF;
      endcase
      fields.strobeCompOff =
         extConfigLoopDriveLatency[STROBE_COMP_OFF_BIT];
      fields.outputOff = extConfigLoopDriveLatency[OUTPUT_OFF_BIT];
      fields.partialArray =
         extConfigRefreshFeatures[PARTIAL_LSB +: 3];
      fields.dccControl = extConfigRefreshFeatures[DCC_BIT];
      fields.fastRefresh = extConfigRefreshFeatures[FAST_REFRESH_BIT];
   end

   // self refresh parks the loop without touching the stored bit
   assign loopRunning = fields.loopEnabled && !selfRefresh;

   // trim mode and adjust burst capture
   emrt_trim_mode_t next_trimMode;
   emrt_adj_state_t adjState;
   emrt_adj_state_t next_adjState;
   logic [1:0] beatCount;
   logic [1:0] next_beatCount;
   logic [3:0] code;
   logic [3:0] next_code;
   logic loadDefault;
   logic next_loadDefault;
   logic apply;
   logic next_apply;
   emrt_step_t upAct;
   emrt_step_t next_upAct;
   emrt_step_t downAct;
   emrt_step_t next_downAct;
   logic [3:0] fullCode;

   assign fullCode = {code[2:0], dqIn[0]};

   always_comb begin
      next_trimMode = trimMode;
      next_adjState = adjState;
      next_beatCount = beatCount;
      next_code = code;
      next_loadDefault = 1'b0;
      next_apply = 1'b0;
      next_upAct = STEP_HOLD;
      next_downAct = STEP_HOLD;
      if (loopWrite) begin
         next_adjState = ADJ_IDLE;
         next_beatCount = 2'h0;
         unique case (trimField)
            TRIM_DRIVE_HIGH: next_trimMode = TRIM_HIGH;
            TRIM_DRIVE_LOW: next_trimMode = TRIM_LOW;
            TRIM_ADJUST: begin
               next_trimMode = TRIM_ADJ;
               next_adjState = ADJ_COLLECT;
            end
            TRIM_DEFAULT: begin
               next_trimMode = TRIM_OFF;
               next_loadDefault = 1'b1;
            end
            // exit and undefined codes keep the counters as they are
            default: next_trimMode = TRIM_OFF;
         endcase
      end else begin
         unique case (adjState)
            ADJ_IDLE: begin
               next_beatCount = 2'h0;
            end
            ADJ_COLLECT: begin
               if (dqBeat) begin
                  // every data line carries the same code; lane 0 is used
                  next_code = fullCode;
                  next_beatCount = beatCount + 2'h1;
                  if (beatCount == LAST_BEAT) begin
                     next_adjState = ADJ_IDLE;
                     next_apply = 1'b1;
                     unique case (fullCode)
                        CODE_UP_INC: next_upAct = STEP_INC;
                        CODE_UP_DEC: next_upAct = STEP_DEC;
                        CODE_DN_INC: next_downAct = STEP_INC;
                        CODE_DN_DEC: next_downAct = STEP_DEC;
                        CODE_BOTH_INC: begin
                           next_upAct = STEP_INC;
                           next_downAct = STEP_INC;
                        end
                        CODE_UPDEC_DNINC: begin
                           next_upAct = STEP_DEC;
                           next_downAct = STEP_INC;
                        end
                        CODE_UPINC_DNDEC: begin
                           next_upAct = STEP_INC;
                           next_downAct = STEP_DEC;
                        end
                        CODE_BOTH_DEC: begin
                           next_upAct = STEP_DEC;
                           next_downAct = STEP_DEC;
                        end
                        default: begin
                           next_upAct = STEP_HOLD;
                           next_downAct = STEP_HOLD;
                        end
                     endcase
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         trimMode <= TRIM_OFF;
         adjState <= ADJ_IDLE;
         beatCount <= 2'h0;
         code <= 4'h0;
         loadDefault <= 1'b0;
         apply <= 1'b0;
         upAct <= STEP_HOLD;
         downAct <= STEP_HOLD;
      end else begin
         trimMode <= next_trimMode;
         adjState <= next_adjState;
         beatCount <= next_beatCount;
         code <= next_code;
         loadDefault <= next_loadDefault;
         apply <= next_apply;
         upAct <= next_upAct;
         downAct <= next_downAct;
      end
   end

   emrt_trim_steps u_trim_steps (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .loadDefault(loadDefault),
      .apply(apply),
      .upAct(upAct),
      .downAct(downAct),
      .pullUpStep(pullUpStep),
      .pullDownStep(pullDownStep)
   );

   // calibration pin drive
   emrt_pins_t next_pins;

   always_comb begin
      next_pins = '0;
      unique case (trimMode)
         TRIM_HIGH: begin
            next_pins.dq = '1;
            next_pins.dqs = '1;
            next_pins.dqsComp = '0;
         end
         TRIM_LOW: begin
            next_pins.dq = '0;
            next_pins.dqs = '0;
            next_pins.dqsComp = '1;
         end
         default: next_pins.dq = '0;
      endcase
      if ((trimMode == TRIM_HIGH || trimMode == TRIM_LOW)
          && !fields.outputOff) begin
         next_pins.dqOe = 1'b1;
         next_pins.dqsOe = 1'b1;
         next_pins.dqsCompOe = !fields.strobeCompOff;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!reset_n) begin
         pins <= '0;
      end else begin
         pins <= next_pins;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   sequence s_adjust_write;
      loopWrite && trimField == TRIM_ADJUST;
   endsequence
   sequence s_four_beats;
      (dqBeat && !loopWrite) [*4];
   endsequence

   a_loop_reg_store: assert property (
      loopWrite |=> extConfigLoopDriveLatency == $past(cmd.addr))
      else $error("first register did not take address value");
   a_refresh_reg_store: assert property (
      extWrite && regSel == SEL_REFRESH
      |=> extConfigRefreshFeatures == $past(cmd.addr))
      else $error("second register did not take address value");
   a_third_reg_store: assert property (
      extWrite && regSel == SEL_THIRD
      |=> extConfigReservedThird == $past(cmd.addr))
      else $error("third register did not take address value");
   a_busy_banks_ignored: assert property (
      !allBanksIdle |=> $stable(extConfigLoopDriveLatency)
      && $stable(extConfigRefreshFeatures))
      else $error("register changed while banks were open");
   a_loop_self_refresh: assert property (
      selfRefresh |-> !loopRunning)
      else $error("loop running during self refresh");
   a_loop_bit_sense: assert property (
      !selfRefresh && !extConfigLoopDriveLatency[LOOP_OFF_BIT]
      |-> loopRunning)
      else $error("loop not running with enable bit low");
   a_term_fifty: assert property (
      extConfigLoopDriveLatency[TERM_HI_BIT]
      && extConfigLoopDriveLatency[TERM_LO_BIT] |-> fields.term == TERM_50)
      else $error("termination decode wrong for 1,1");
   a_trim_decode: assert property (
      loopWrite && trimField == TRIM_DRIVE_LOW |=> trimMode == TRIM_LOW)
      else $error("drive-low code not decoded");
   a_drive_high_pins: assert property (
      trimMode == TRIM_HIGH && !fields.outputOff
      |=> pins.dqOe && pins.dq == '1 && pins.dqs == '1 && pins.dqsComp == '0)
      else $error("drive-high pin levels wrong");
   a_output_off: assert property (
      fields.outputOff |=> !pins.dqOe && !pins.dqsOe && !pins.dqsCompOe)
      else $error("pins driven while output disabled");
   a_adjust_burst: assert property (
      s_adjust_write ##1 s_four_beats |=> apply)
      else $error("adjust burst did not produce an update");
   a_reserved_hold: assert property (
      apply && code == 4'hF |-> upAct == STEP_HOLD && downAct == STEP_HOLD)
      else $error("reserved code changed a trim step");
   a_exit_keeps_steps: assert property (
      loopWrite && trimField == TRIM_EXIT |=> ##1 $stable(pullUpStep)
      && $stable(pullDownStep))
      else $error("exit write disturbed trim steps");
endmodule

// ### tb/emrt_ctrl_model.sv
// controller-side model: issues extended register writes and adjust bursts
// assumes the bench calls its tasks from the rising-edge time step
`timescale 1ns/1ps
module emrt_ctrl_model
   import emrt_pkg::*;
(
   input wire logic core_clk,
   output emrt_cmd_t cmd,
   output logic cke,
   output logic allBanksIdle,
   output logic [DQ_W-1:0] dqIn,
   output logic dqBeat
);
   initial begin
      cke = 1'b1;
      cmd = {4'hF, 3'h0, 14'h0000};
      allBanksIdle = 1'b1;
      dqIn = 16'h0000;
      dqBeat = 1'b0;
   end

   // one write; afterwards the chip is deselected and the address inverted
   task automatic wr(input logic [1:0] ba, input logic [ADDR_W-1:0] a,
                     input logic idle, input logic en);
      @(posedge core_clk);
      cke <= en;
      allBanksIdle <= idle;
      // only mode writes go out, so no read can follow a loop enable early
      cmd <= {4'h0, 1'b0, ba, a};
      @(posedge core_clk);
      cke <= 1'b1;
      allBanksIdle <= 1'b1;
      // the deselect cycle keeps two writes at least two edges apart
      cmd <= {4'hF, 1'b0, ~ba, ~a};
   endtask

   // same code bit on every lane, bit time zero first
   task automatic burst(input logic [3:0] code);
      for (int i = 0; i < 4; i++) begin
         dqBeat <= 1'b1;
         dqIn <= {DQ_W{code[3-i]}};
         @(posedge core_clk);
      end
      dqBeat <= 1'b0;
      dqIn <= ~dqIn;
   endtask
endmodule

// ### tb/ext_mode_regs_driver_trim_bench.sv
// self-checking bench for the extended register bank and driver trim
// assumes emrt_ctrl_model drives the command side; model kept in integers
`timescale 1ns/1ps
module ext_mode_regs_driver_trim_bench;
   import emrt_pkg::*;
   logic core_clk, reset_n, selfRefresh, cke, allBanksIdle, dqBeat;
   logic loopRunning;
   emrt_cmd_t cmd;
   logic [DQ_W-1:0] dqIn;
   emrt_pins_t pins;
   emrt_config_t cfg;
   emrt_trim_mode_t trimMode;
   logic [STEP_W-1:0] upStep, dnStep;
   logic [ADDR_W-1:0] regA, regB, regC;
   int error_cnt = 0, cmp_count = 0, cycles = 0, seed = 612;
   int mReg[4] = '{0, 0, 0, 0};
   int mUp = 8, mDn = 8;

   emrt_ctrl_model ctrl (.core_clk(core_clk), .cmd(cmd), .cke(cke),
      .allBanksIdle(allBanksIdle), .dqIn(dqIn), .dqBeat(dqBeat));
   emrt_ext_regs DUT (.core_clk(core_clk), .reset_n(reset_n), .cke(cke),
      .cmd(cmd), .allBanksIdle(allBanksIdle), .selfRefresh(selfRefresh),
      .dqIn(dqIn), .dqBeat(dqBeat), .pins(pins), .fields(cfg),
      .loopRunning(loopRunning), .trimMode(trimMode),
      .pullUpStep(upStep), .pullDownStep(dnStep),
      .extConfigLoopDriveLatency(regA), .extConfigRefreshFeatures(regB),
      .extConfigReservedThird(regC));

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // a run of about 650 cycles is expected
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 4000) begin
         error_cnt++;
         give_verdict();
      end
   end

   task automatic cmp_val(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic int sat(input int v);
      return (v > 15) ? 15 : ((v < 0) ? 0 : v);
   endfunction

   task automatic put(input logic [1:0] ba, input logic [ADDR_W-1:0] a,
                      input logic idle, input logic en);
      ctrl.wr(ba, a, idle, en);
      if (idle && en && ba != 2'h0) begin
         mReg[ba] = a;
         if (ba == 2'h1 && a[9:7] == TRIM_DEFAULT) begin
            mUp = 8;
            mDn = 8;
         end
      end
   endtask

   task automatic check_regs();
      logic [ADDR_W-1:0] r1, r2;
      @(negedge core_clk);
      r1 = 14'(mReg[1]);
      r2 = 14'(mReg[2]);
      cmp_val("first", r1, regA);
      cmp_val("second", r2, regB);
      cmp_val("third", 14'(mReg[3]), regC);
      cmp_val("loop", !r1[0], cfg.loopEnabled);
      cmp_val("half", r1[1], cfg.halfDrive);
      cmp_val("delay", r1[5:3], cfg.postedDelay);
      cmp_val("term", {r1[6], r1[2]}, cfg.term);
      cmp_val("compoff", r1[10], cfg.strobeCompOff);
      cmp_val("outoff", r1[12], cfg.outputOff);
      cmp_val("refresh", {r2[7], r2[3], r2[2:0]},
         {cfg.fastRefresh, cfg.dccControl, cfg.partialArray});
      cmp_val("running", !r1[0] && !selfRefresh, loopRunning);
   endtask

   task automatic cmp_pins(input emrt_pins_t e);
      cmp_val("oe", {e.dqOe, e.dqsOe, e.dqsCompOe},
         {pins.dqOe, pins.dqsOe, pins.dqsCompOe});
      if (e.dqOe) begin
         cmp_val("dq", e.dq, pins.dq);
         cmp_val("dqs", e.dqs, pins.dqs);
      end
      if (e.dqsCompOe)
         cmp_val("dqsComp", e.dqsComp, pins.dqsComp);
   endtask

   task automatic drive_case(input logic [2:0] trim,
                             input logic [ADDR_W-1:0] extra);
      logic hi, on;
      emrt_pins_t e;
      hi = (trim == TRIM_DRIVE_HIGH);
      on = !extra[OUTPUT_OFF_BIT];
      e = {{DQ_W{hi}}, on, {STROBE_W{hi}}, on, {STROBE_W{!hi}},
         on && !extra[STROBE_COMP_OFF_BIT]};
      put(2'h1, extra | {4'h0, trim, 7'h00}, 1'b1, 1'b1);
      @(posedge core_clk);
      @(negedge core_clk);
      cmp_pins(e);
      cmp_val("mode", hi ? TRIM_HIGH : TRIM_LOW, trimMode);
      put(2'h1, extra, 1'b1, 1'b1);
      check_regs();
   endtask

   task automatic check_steps();
      @(negedge core_clk);
      cmp_val("pullUp", mUp, upStep);
      cmp_val("pullDown", mDn, dnStep);
   endtask

   task automatic adjust(input logic [3:0] code);
      logic [ADDR_W-1:0] base;
      int up, dn;
      // calibration runs with the loop enabled and the delay kept
      base = 14'(mReg[1]) & 14'h3C7E;
      put(2'h1, base | {4'h0, TRIM_ADJUST, 7'h00}, 1'b1, 1'b1);
      ctrl.burst(code);
      up = 0;
      dn = 0;
      case (code)
         4'h1: up = 1;
         4'h2: up = -1;
         4'h4: dn = 1;
         4'h8: dn = -1;
         4'h5: begin up = 1; dn = 1; end
         4'h6: begin up = -1; dn = 1; end
         4'h9: begin up = 1; dn = -1; end
         4'hA: begin up = -1; dn = -1; end
         default: ;
      endcase
      mUp = sat(mUp + up);
      mDn = sat(mDn + dn);
      repeat (2) @(posedge core_clk);
      check_steps();
      cmp_val("mode", TRIM_ADJ, trimMode);
      put(2'h1, base, 1'b1, 1'b1);
   endtask

   initial begin
      int r;
      logic [ADDR_W-1:0] m;
      reset_n = 1'b0;
      selfRefresh = 1'b0;
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      check_regs();
      check_steps();
      cmp_val("mode", TRIM_OFF, trimMode);
      cmp_val("idleoe", 3'h0, {pins.dqOe, pins.dqsOe, pins.dqsCompOe});
      // random writes, some refused by bank state or clock enable
      for (int i = 0; i < 24; i++) begin
         r = $random(seed);
         // reserved bits of the second and third register go out as zero
         m = (i % 4 == 2) ? 14'h008F : ((i % 4 == 3) ? 14'h0000 : 14'h3C7F);
         put(2'(i % 4), 14'(r) & m, r[20] | r[24], r[21] | r[23]);
         selfRefresh <= r[22];
         check_regs();
      end
      selfRefresh <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         drive_case(TRIM_DRIVE_HIGH, (k == 1) ? 14'h0400 : 14'h0000);
         drive_case(TRIM_DRIVE_LOW, (k == 2) ? 14'h1000 : 14'h0000);
      end
      put(2'h1, 14'h0018, 1'b1, 1'b1);
      adjust(CODE_UP_INC);
      put(2'h1, 14'h0398, 1'b1, 1'b1);
      repeat (2) @(posedge core_clk);
      check_steps();
      cmp_val("mode", TRIM_OFF, trimMode);
      put(2'h1, 14'h0018, 1'b1, 1'b1);
      for (int c = 0; c < 16; c++)
         adjust(4'(c));
      for (int c = 0; c < 9; c++)
         adjust(CODE_UPINC_DNDEC);
      for (int c = 0; c < 18; c++)
         adjust(CODE_UPDEC_DNINC);
      for (int c = 0; c < 10; c++) begin
         r = $random(seed);
         adjust(r[3:0]);
      end
      // beats outside an adjust write must be ignored
      ctrl.burst(CODE_BOTH_INC);
      repeat (3) @(posedge core_clk);
      check_steps();
      check_regs();
      give_verdict();
   end
endmodule
